// ==== design/sdap_core.v ====
// Contract
// - data register holds transmit or received byte
// - data access allowed while event flag set
// - transmit most significant bit first
// - first received bit lands in MSB
// - shift in bus value while transmitting
// - lost arbitration keeps observed byte
// - slave compares upper seven address bits
// - own address MSB matches first bit
// - general call only when bit0 set
// - address register ignored in master mode
// - event flag set by hardware, software clears
// - ack level from ack_assert when addressed
// - free timer counts while clock and data both high
`include "sdap_consts.vh"

module sdap_core #(
	parameter RATE_W = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_n,
	input wire master_mode,
	input wire master_tx,
	input wire event_set,
	input wire start_sent,
	input wire [1:0] busy_in,
	output reg event_flag,
	output reg irq_req,
	output reg addr_match,
	output reg byte_done,
	output reg bus_free_timeout,
	output reg timer_reload,
	output reg timer_count,
	output reg data_access_err
);
	// ***********************************************
	// pin synchronisers
	// ***********************************************
	wire scl_lvl;
	wire scl_rise;
	wire scl_fall;
	wire sda_lvl;
	wire sda_rise;
	wire sda_fall;
	sdap_sync u_scl (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin(scl_in),
		.level(scl_lvl),
		.rise(scl_rise),
		.fall(scl_fall)
	);
	sdap_sync u_sda (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin(sda_in),
		.level(sda_lvl),
		.rise(sda_rise),
		.fall(sda_fall)
	);

	// ***********************************************
	// registers
	// ***********************************************
	reg [7:0] serial_control_reg;
	reg [7:0] own_address_reg;
	reg [7:0] bus_rate_reg;
	reg [7:0] shift_data_reg;
	reg [3:0] bit_cnt;
	reg first_byte;
	reg addressed;
	reg [RATE_W-1:0] free_cnt;

	wire interface_enable = serial_control_reg[`SDAP_BIT_ENABLE];
	wire ack_assert = serial_control_reg[`SDAP_BIT_ACK];
	wire free_timer_enable = serial_control_reg[`SDAP_BIT_FREE_TE];
	wire low_timeout_enable = serial_control_reg[`SDAP_BIT_LOW_TE];
	wire [6:0] own_address_bits = own_address_reg[7:1];
	wire general_call_enable = own_address_reg[0];

	wire start_det = scl_lvl & sda_fall;
	wire stop_det = scl_lvl & sda_rise;
	wire data_bit = bit_cnt < `SDAP_BYTE_BITS;
	wire ack_bit = bit_cnt == `SDAP_BYTE_BITS;
	wire [7:0] rx_byte = {shift_data_reg[6:0], sda_lvl};
	wire ctrl_wr = sfr_wr && sfr_addr == `SDAP_ADDR_CTRL;
	wire data_sel = sfr_addr == `SDAP_ADDR_DATA;
	wire event_clr = ctrl_wr && !sfr_wdata[`SDAP_BIT_EVENT];

	// ***********************************************
	// address compare
	// ***********************************************
	reg hit;
	always @* begin
		hit = 1'b0;
		if (!master_mode && ack_assert) begin
			if (rx_byte[7:1] == own_address_bits)
				hit = 1'b1;
			if (rx_byte[7:1] == `SDAP_GC_ADDR && general_call_enable)
				hit = 1'b1;
		end
	end

	// ***********************************************
	// control, address and rate registers
	// ***********************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			serial_control_reg <= `SDAP_CTRL_RESET;
			own_address_reg <= `SDAP_OWN_RESET;
			bus_rate_reg <= `SDAP_RATE_RESET;
		end else begin
			if (ctrl_wr)
				serial_control_reg <= sfr_wdata;
			if (sfr_wr && sfr_addr == `SDAP_ADDR_OWN)
				own_address_reg <= sfr_wdata;
			if (sfr_wr && sfr_addr == `SDAP_ADDR_RATE)
				bus_rate_reg <= sfr_wdata;
		end
	end

	// ***********************************************
	// event flag: set wins over clear
	// ***********************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			event_flag <= 1'b0;
			irq_req <= 1'b0;
		end else begin
			if (event_set && interface_enable) begin
				event_flag <= 1'b1;
				irq_req <= 1'b1;
			end else if (event_clr) begin
				event_flag <= 1'b0;
				irq_req <= 1'b0;
			end
		end
	end

	// ***********************************************
	// shift register and bit counter
	// ***********************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			shift_data_reg <= 8'h00;
			bit_cnt <= 4'h0;
			first_byte <= 1'b0;
			addressed <= 1'b0;
			addr_match <= 1'b0;
			byte_done <= 1'b0;
			sda_out <= 1'b1;
			sda_oe_n <= 1'b1;
			data_access_err <= 1'b0;
		end else begin
			byte_done <= 1'b0;
			data_access_err <= 1'b0;
			if (sfr_wr && data_sel) begin
				if (event_flag || !interface_enable)
					shift_data_reg <= sfr_wdata;
				else
					data_access_err <= 1'b1;
			end else if (sfr_rd && data_sel && interface_enable && !event_flag)
				data_access_err <= 1'b1;
			if (!interface_enable) begin
				bit_cnt <= 4'h0;
				addressed <= 1'b0;
				addr_match <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (start_det || start_sent) begin
				bit_cnt <= 4'h0;
				first_byte <= 1'b1;
				addressed <= 1'b0;
				addr_match <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (stop_det) begin
				bit_cnt <= 4'h0;
				addressed <= 1'b0;
				sda_oe_n <= 1'b1;
			end else if (scl_rise) begin
				if (data_bit) begin
					// bus value shifted in even while sending
					shift_data_reg <= rx_byte;
					if (bit_cnt == 4'h7) begin
						byte_done <= 1'b1;
						if (first_byte) begin
							first_byte <= 1'b0;
							addressed <= hit;
							addr_match <= hit;
						end
					end
				end
				bit_cnt <= ack_bit ? 4'h0 : bit_cnt + 4'h1;
			end else if (scl_fall) begin
				if (data_bit && master_tx && !event_flag) begin
					sda_out <= shift_data_reg[7];
					sda_oe_n <= shift_data_reg[7];
				end else if (ack_bit && !master_tx) begin
					sda_out <= ~(ack_assert && (addressed || master_mode));
					sda_oe_n <= ~(ack_assert && (addressed || master_mode));
				end else begin
					sda_out <= 1'b1;
					sda_oe_n <= 1'b1;
				end
			end
		end
	end

	// ***********************************************
	// bus free and clock low timers
	// ***********************************************
	always @(posedge sys_clk) begin
		if (rst) begin
			free_cnt <= {RATE_W{1'b0}};
			bus_free_timeout <= 1'b0;
			timer_reload <= 1'b0;
			timer_count <= 1'b0;
		end else begin
			bus_free_timeout <= 1'b0;
			if (!free_timer_enable || !scl_lvl || !sda_lvl)
				free_cnt <= bus_rate_reg[RATE_W-1:0];
			else if (&free_cnt) begin
				free_cnt <= bus_rate_reg[RATE_W-1:0];
				bus_free_timeout <= 1'b1;
			end else
				free_cnt <= free_cnt + {{(RATE_W-1){1'b0}}, 1'b1};
			timer_reload <= low_timeout_enable & scl_lvl;
			timer_count <= low_timeout_enable & ~scl_lvl;
		end
	end

	// ***********************************************
	// register read
	// ***********************************************
	always @(posedge sys_clk) begin
		if (rst)
			sfr_rdata <= 8'h00;
		else if (sfr_rd) begin
			case (sfr_addr)
			`SDAP_ADDR_CTRL: sfr_rdata <= {busy_in[0], serial_control_reg[6:4], event_flag,
				serial_control_reg[2:0]};
			`SDAP_ADDR_DATA: sfr_rdata <= shift_data_reg;
			`SDAP_ADDR_OWN: sfr_rdata <= own_address_reg;
			`SDAP_ADDR_RATE: sfr_rdata <= bus_rate_reg;
			default: sfr_rdata <= 8'h00;
			endcase
		end
	end
endmodule

// ==== design/sdap_consts.vh ====
`ifndef SDAP_CONSTS_VH
`define SDAP_CONSTS_VH

// ***********************************************
// special function register addresses
// ***********************************************
`define SDAP_ADDR_CTRL 8'hc0
`define SDAP_ADDR_DATA 8'hc2
`define SDAP_ADDR_OWN 8'hc3
`define SDAP_ADDR_RATE 8'hcf

// ***********************************************
// control register fields and resets
// ***********************************************
`define SDAP_BIT_BUSY 7
`define SDAP_BIT_ENABLE 6
`define SDAP_BIT_START 5
`define SDAP_BIT_STOP 4
`define SDAP_BIT_EVENT 3
`define SDAP_BIT_ACK 2
`define SDAP_BIT_FREE_TE 1
`define SDAP_BIT_LOW_TE 0
`define SDAP_CTRL_RESET 8'h00
`define SDAP_OWN_RESET 8'h00
`define SDAP_RATE_RESET 8'h00
`define SDAP_GC_ADDR 7'h00
`define SDAP_BYTE_BITS 4'h8

`endif

// ==== design/sdap_sync.v ====
// ***********************************************
// three-stage pin synchroniser
// ***********************************************
module sdap_sync (
	input wire sys_clk,
	input wire rst,
	input wire pin,
	output reg level,
	output reg rise,
	output reg fall
);
	reg s1;
	reg s2;
	reg s3;
	always @(posedge sys_clk) begin
		if (rst) begin
			s1 <= 1'b1;
			s2 <= 1'b1;
			s3 <= 1'b1;
			level <= 1'b1;
			rise <= 1'b0;
			fall <= 1'b0;
		end else begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
			rise <= 1'b0;
			fall <= 1'b0;
			// change counts once stages two and three agree
			if (s2 == s3 && s3 != level) begin
				level <= s3;
				rise <= s3;
				fall <= ~s3;
			end
		end
	end
endmodule

// ==== test/sdap_checker_properties.sv ====
`include "sdap_consts.vh"
module sdap_checker (
	input logic sys_clk,
	input logic rst,
	input logic [7:0] sfr_addr,
	input logic sfr_wr,
	input logic sfr_rd,
	input logic [7:0] sfr_rdata,
	input logic sda_out,
	input logic sda_oe_n,
	input logic master_mode,
	input logic event_set,
	input logic event_flag,
	input logic addr_match,
	input logic byte_done,
	input logic bus_free_timeout,
	input logic timer_reload,
	input logic timer_count,
	input logic data_access_err
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking dc @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	flag_rise_cause_a: assert property ($rose(event_flag) |-> $past(event_set))
		else $error("flag rose alone");
	flag_hold_a: assert property (event_flag && !(sfr_wr && sfr_addr == `SDAP_ADDR_CTRL)
		|=> event_flag) else $error("flag lost");
	data_err_cause_a: assert property (data_access_err |-> !$past(event_flag))
		else $error("bad access error");
	byte_pulse_a: assert property (byte_done |=> !byte_done) else $error("long byte pulse");
	free_pulse_a: assert property (bus_free_timeout |=> !bus_free_timeout)
		else $error("long timeout");
	timer_mode_a: assert property (!(timer_reload && timer_count)) else $error("timer both");
	oe_match_a: assert property (sda_oe_n == sda_out) else $error("pin enable split");
	master_addr_a: assert property ($rose(addr_match) |-> !$past(master_mode))
		else $error("match in master");
	rdata_hold_a: assert property (!$past(sfr_rd) |-> $stable(sfr_rdata))
		else $error("read data moved");
	cover property ($rose(addr_match));
	cover property (data_access_err);
	cover property (bus_free_timeout);
endmodule
bind sdap_core sdap_checker chk_u (.*);

// ==== test/sdap_bus_model.sv ====
module sdap_bus_model (
	input logic sys_clk,
	input logic sda,
	output logic scl = 1'h1,
	output logic sda_m = 1'h1
);
	timeunit 1ns;
	timeprecision 1ps;
	task automatic w(input int n);
		#(n * 31.25);
	endtask
	task automatic start;
		sda_m <= 1'h0;
		w(1);
		scl <= 1'h0;
		w(1);
		@(posedge sys_clk);
	endtask
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--) begin
			sda_m <= tx[i];
			w(1);
			scl <= 1'h1;
			w(2);
			rx[i] = sda;
			scl <= 1'h0;
			w(1);
		end
		@(posedge sys_clk);
	endtask
	task automatic stop;
		sda_m <= 1'h0;
		w(1);
		scl <= 1'h1;
		w(1);
		sda_m <= 1'h1;
		w(1);
		@(posedge sys_clk);
	endtask
endmodule

// ==== test/sdap_core_bench.sv ====
`include "sdap_consts.vh"
`define CK(a, b) begin tests_run++; if ((a) !== (b)) begin mismatches++; \
	$display("[ERR] %0t mismatch %h!=%h", $time, a, b); end end
module sdap_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [7:0] ctl = `SDAP_ADDR_CTRL, dat = `SDAP_ADDR_DATA;
	logic sys_clk = 1'h0, rst = 1'h1, sfr_wr = 1'h0, sfr_rd = 1'h0, event_set = 1'h0;
	logic master_mode = 1'h0, master_tx = 1'h0, start_sent = 1'h0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic sda_out, sda_oe_n, event_flag, irq_req, addr_match, byte_done, bus_free_timeout;
	logic timer_reload, timer_count, data_access_err;
	logic [8:0] rx;
	wire scl_in, sda_m;
	// pull-up: high unless someone drives low
	wire sda_in = sda_m & (sda_oe_n | sda_out);
	int mismatches = 0, tests_run = 0;
	int bytes_seen = 0;
	// own reg, address byte, master, match
	logic [17:0] tbl [5] = '{{8'ha5, 8'ha4, 2'h1}, {8'ha5, 8'h24, 2'h0}, {8'ha5, 8'h00, 2'h1},
		{8'ha4, 8'h00, 2'h0}, {8'ha4, 8'ha4, 2'h2}};
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (byte_done)
			bytes_seen++;
	sdap_core dut_u (.busy_in(2'h0), .*);
	sdap_bus_model model_u (.sys_clk(sys_clk), .sda(sda_in), .scl(scl_in), .sda_m(sda_m));
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_wr <= w;
		sfr_rd <= !w;
		@(posedge sys_clk);
		sfr_wr <= 1'h0;
		sfr_rd <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic ev;
		event_set <= 1'h1;
		@(posedge sys_clk);
		event_set <= 1'h0;
		@(posedge sys_clk);
	endtask
	task automatic finish_test;
		if (mismatches == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'h0;
		acc(1'h0, `SDAP_ADDR_OWN, 8'h00);
		`CK(sfr_rdata, `SDAP_OWN_RESET)
		acc(1'h1, ctl, 8'h44);
		acc(1'h1, dat, 8'h11);
		`CK(data_access_err, 1'h1)
		ev;
		`CK(event_flag, 1'h1)
		`CK(irq_req, 1'h1)
		acc(1'h0, dat, 8'h00);
		`CK(sfr_rdata, 8'h00)
		acc(1'h1, dat, 8'h3c);
		`CK(data_access_err, 1'h0)
		acc(1'h0, dat, 8'h00);
		`CK(sfr_rdata, 8'h3c)
		acc(1'h1, ctl, 8'h44);
		`CK(event_flag, 1'h0)
		`CK(irq_req, 1'h0)
		for (int i = 0; i < 5; i++) begin
			acc(1'h1, `SDAP_ADDR_OWN, tbl[i][17:10]);
			master_mode <= tbl[i][1];
			model_u.start();
			model_u.xfer({tbl[i][9:2], 1'h1}, rx);
			`CK(addr_match, tbl[i][0])
			if (!tbl[i][1])
				`CK(rx[0], !tbl[i][0])
			ev;
			acc(1'h0, dat, 8'h00);
			`CK(sfr_rdata, tbl[i][9:2])
			model_u.stop();
			acc(1'h1, dat, 8'hb5);
			acc(1'h1, ctl, 8'h44);
		end
		// far end forces only the last data bit low
		master_tx <= 1'h1;
		model_u.start();
		model_u.xfer(9'h1fd, rx);
		`CK(rx[8:1], 8'hb4)
		master_tx <= 1'h0;
		ev;
		acc(1'h0, dat, 8'h00);
		`CK(sfr_rdata, 8'hb4)
		model_u.stop();
		`CK(bytes_seen, 6)
		acc(1'h1, `SDAP_ADDR_RATE, 8'hf0);
		acc(1'h1, ctl, 8'h47);
		for (int k = 0; k < 64 && bus_free_timeout !== 1'h1; k++)
			@(posedge sys_clk);
		`CK(bus_free_timeout, 1'h1)
		if (bus_free_timeout !== 1'h1)
			finish_test;
		`CK(timer_reload, 1'h1)
		model_u.scl <= 1'h0;
		model_u.w(2);
		`CK(timer_count, 1'h1)
		`CK(timer_reload, 1'h0)
		finish_test;
	end
endmodule
